// *** core/ref_pkg.sv ***
// Constants for the regulator event flag block.
// Assumes an 8-bit register port driven by the serial interface logic.
package ref_pkg;
    localparam logic [7:0] ADDR_RESET_EVENT  = 8'h1a;
    localparam logic [7:0] ADDR_SW_EVENT     = 8'h1b;
    localparam logic [7:0] ADDR_LIN_EVENT    = 8'h1c;
    localparam logic [7:0] ADDR_SOFT_RESET   = 8'h18;
    localparam logic [7:0] ADDR_SUMMARY      = 8'h19;
    localparam logic [7:0] FLAGS_RESET_VALUE = 8'h00;
    // Flag positions; the REG0/REG1 ones are shared by both regulator registers
    localparam int BIT_RESET_EVENT   = 0;
    localparam int BIT_REG0_CURLIMIT = 0;
    localparam int BIT_REG0_SHORT    = 1;
    localparam int BIT_REG0_PGOOD    = 2;
    localparam int BIT_REG1_CURLIMIT = 4;
    localparam int BIT_REG1_SHORT    = 5;
    localparam int BIT_REG1_PGOOD    = 6;
    localparam int BIT_SOFT_RESET    = 0;
    localparam int BIT_SW_SUMMARY    = 5;
    localparam int BIT_LIN_SUMMARY   = 6;
    // Implemented bits; 7 and 3 are reserved in the regulator registers, 7:1 in the reset register
    localparam logic [7:0] REG_EVENT_MASK = 8'h77;
    localparam logic [7:0] RST_EVENT_MASK = 8'h01;
    // Short-circuit qualification time
    localparam int  CLK_HZ        = 25_000_000;
    localparam int  SHORT_TIME_US = 1000;
    localparam int  SHORT_CYCLES  = (CLK_HZ / 1_000_000) * SHORT_TIME_US + 1;
    localparam int  SHORT_CNT_W   = 16;
    localparam int  NUM_SHORT     = 4;
endpackage

// *** core/ref_event_flags.sv ***
// Latched write-one-to-clear event flags for the regulator power manager.
// Assumes sync inputs from the analog detectors and a byte register port.
// Assumes the serial interface turns each host access into a one-cycle strobe.
// Assumes the sequencer acts on the reset and startup strobes it receives.
`timescale 1ns/100ps
`default_nettype none
module ref_event_flags (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       analog_supply_low,
    input  wire logic [1:0] sw_powergood_event,
    input  wire logic [1:0] sw_below_short,
    input  wire logic [1:0] sw_curlimit_active,
    input  wire logic [1:0] lin_powergood_event,
    input  wire logic [1:0] lin_below_short,
    input  wire logic [1:0] lin_curlimit_active,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            sw_summary_flag,
    output logic            linear_summary_flag,
    output logic            regulators_off,
    output logic            defaults_load,
    output logic            startup_start,
    output logic            serial_if_reset
);
    import ref_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]                      reset_event_flags;
        logic [7:0]                      switcher_event_flags;
        logic [7:0]                      linear_event_flags;
        logic [NUM_SHORT-1:0][SHORT_CNT_W-1:0] short_cnt;
        logic [NUM_SHORT-1:0]            short_done;
        logic [7:0]                      rdata;
        logic                            supply_low_d;
        logic                            soft_reset_pulse;
        logic                            reset_pulse;
        logic                            startup_pulse;
    } ref_state_t;

    ref_state_t st_reg;
    ref_state_t st_next;

    logic [NUM_SHORT-1:0] below_vec;
    logic [NUM_SHORT-1:0] short_hit;
    logic [7:0]           sw_set;
    logic [7:0]           lin_set;
    logic                 reset_event;
    logic                 soft_req;

    // Switcher timers take indices 0 and 1, linear timers 2 and 3
    assign below_vec = {lin_below_short, sw_below_short};

    // ------------------------------------------------------------
    // Short-circuit qualification timers
    // ------------------------------------------------------------
    // Timer fires once per low period, restarting only when the below input drops or on a reset event, so a held short does
    // not re-set a flag the host has just cleared.
    // Counter stops at the hit value while below, so it cannot wrap.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SHORT; gi++) begin : g_short
            assign short_hit[gi] = below_vec[gi] && !st_reg.short_done[gi]
                && (st_reg.short_cnt[gi] == SHORT_CNT_W'(SHORT_CYCLES - 1));
        end
    endgenerate

    // ------------------------------------------------------------
    // Event set vectors
    // ------------------------------------------------------------
    // Level inputs set their flag on every cycle they stand high, so a
    // clear-write during an active current limit is overridden at once.
    always_comb begin
        sw_set = 8'h00;
        lin_set = 8'h00;
        sw_set[BIT_REG1_PGOOD]    = sw_powergood_event[1];
        sw_set[BIT_REG0_PGOOD]    = sw_powergood_event[0];
        sw_set[BIT_REG1_SHORT]    = short_hit[1];
        sw_set[BIT_REG0_SHORT]    = short_hit[0];
        sw_set[BIT_REG1_CURLIMIT] = sw_curlimit_active[1];
        sw_set[BIT_REG0_CURLIMIT] = sw_curlimit_active[0];
        lin_set[BIT_REG1_PGOOD]    = lin_powergood_event[1];
        lin_set[BIT_REG0_PGOOD]    = lin_powergood_event[0];
        lin_set[BIT_REG1_SHORT]    = short_hit[3];
        lin_set[BIT_REG0_SHORT]    = short_hit[2];
        lin_set[BIT_REG1_CURLIMIT] = lin_curlimit_active[1];
        lin_set[BIT_REG0_CURLIMIT] = lin_curlimit_active[0];
    end

    // ------------------------------------------------------------
    // Reset event
    // ------------------------------------------------------------
    // soft reset request
    assign soft_req = reg_wr && (reg_addr == ADDR_SOFT_RESET) && reg_wdata[BIT_SOFT_RESET];
    // Only the rising edge counts; a supply held low does not keep flags cleared
    // undervoltage edge or soft reset
    assign reset_event = (analog_supply_low && !st_reg.supply_low_d) || soft_req;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.supply_low_d     = analog_supply_low;
        st_next.soft_reset_pulse = soft_req;
        st_next.reset_pulse      = reset_event;
        st_next.startup_pulse    = st_reg.reset_pulse;

        for (int i = 0; i < NUM_SHORT; i++) begin
            if (!below_vec[i]) begin
                st_next.short_cnt[i]  = '0;
                st_next.short_done[i] = 1'b0;
            end else if (short_hit[i]) begin
                st_next.short_done[i] = 1'b1;
            end else if (!st_reg.short_done[i]) begin
                st_next.short_cnt[i] = st_reg.short_cnt[i] + SHORT_CNT_W'(1);
            end
        end

        // Clear-writes apply first and sets after, so no event falls in the gap
        // write one clears
        if (reg_wr && reg_addr == ADDR_RESET_EVENT)
            st_next.reset_event_flags = st_reg.reset_event_flags & ~reg_wdata;
        if (reg_wr && reg_addr == ADDR_SW_EVENT)
            st_next.switcher_event_flags = st_reg.switcher_event_flags & ~reg_wdata;
        if (reg_wr && reg_addr == ADDR_LIN_EVENT)
            st_next.linear_event_flags = st_reg.linear_event_flags & ~reg_wdata;

        st_next.switcher_event_flags = (st_next.switcher_event_flags | sw_set) & REG_EVENT_MASK;
        st_next.linear_event_flags   = (st_next.linear_event_flags | lin_set) & REG_EVENT_MASK;

        // Pending regulator flags are dropped with the rest of the defaults
        // defaults on reset event
        if (reset_event) begin
            st_next.switcher_event_flags = FLAGS_RESET_VALUE;
            st_next.linear_event_flags   = FLAGS_RESET_VALUE;
            for (int i = 0; i < NUM_SHORT; i++) begin
                st_next.short_cnt[i]  = '0;
                st_next.short_done[i] = 1'b0;
            end
        end
        if (reset_event)
            st_next.reset_event_flags[BIT_RESET_EVENT] = 1'b1;
        st_next.reset_event_flags = st_next.reset_event_flags & RST_EVENT_MASK;

        // Read data is registered and stands until the next read strobe
        if (reg_rd) begin
            case (reg_addr)
                ADDR_RESET_EVENT: st_next.rdata = st_reg.reset_event_flags;
                ADDR_SW_EVENT:    st_next.rdata = st_reg.switcher_event_flags;
                ADDR_LIN_EVENT:   st_next.rdata = st_reg.linear_event_flags;
                ADDR_SUMMARY: begin
                    st_next.rdata = 8'h00;
                    st_next.rdata[BIT_SW_SUMMARY]  = |st_reg.switcher_event_flags;
                    st_next.rdata[BIT_LIN_SUMMARY] = |st_reg.linear_event_flags;
                end
                default:          st_next.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // System reset clears everything, the reset-event flag included
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = st_reg.rdata;
    // Summary bits follow the flags, so they drop with the last clear
    // switcher summary
    assign sw_summary_flag = |st_reg.switcher_event_flags;
    assign linear_summary_flag = |st_reg.linear_event_flags;
    assign regulators_off  = st_reg.reset_pulse;
    assign defaults_load   = st_reg.reset_pulse;
    assign startup_start   = st_reg.startup_pulse;
    assign serial_if_reset = st_reg.soft_reset_pulse;
endmodule
`default_nettype wire

// *** tb/ref_event_flags_sva.sv ***
// Checker for the regulator event flag block, attached by bind.
// Assumes one clock domain; sees only the block's own ports.
`timescale 1ns/100ps
`default_nettype none
module ref_event_flags_sva
    import ref_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       analog_supply_low,
    input wire logic [1:0] sw_curlimit_active,
    input wire logic [1:0] lin_curlimit_active,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       sw_summary_flag,
    input wire logic       linear_summary_flag,
    input wire logic       regulators_off,
    input wire logic       defaults_load,
    input wire logic       startup_start,
    input wire logic       serial_if_reset
);
    logic soft_req_reg;
    // Soft reset write seen at the last edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            soft_req_reg <= 1'b0;
        end else begin
            soft_req_reg <= reg_wr && reg_addr == ADDR_SOFT_RESET && reg_wdata[BIT_SOFT_RESET];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_sw_latch: assert property (
        |sw_curlimit_active && !reg_wr && !analog_supply_low |=> sw_summary_flag)
        else $error("switcher event not latched");
    chk_lin_latch: assert property (
        |lin_curlimit_active && !reg_wr && !analog_supply_low |=> linear_summary_flag)
        else $error("linear event not latched");
    chk_flag_hold: assert property (
        sw_summary_flag && !reg_wr && !analog_supply_low |=> sw_summary_flag)
        else $error("switcher flag lost without clear");
    chk_uv_reset: assert property (
        $rose(analog_supply_low) |=> regulators_off && defaults_load)
        else $error("undervoltage did not reset");
    chk_startup_after: assert property (
        regulators_off |=> startup_start) else $error("startup did not follow");
    chk_soft_reset: assert property (
        soft_req_reg |-> serial_if_reset && regulators_off) else $error("soft reset missed");
    chk_soft_cause: assert property (
        serial_if_reset |-> soft_req_reg) else $error("interface reset without request");
    chk_rsv_zero: assert property (
        reg_rd && reg_addr == ADDR_RESET_EVENT |-> ##[1:2] reg_rdata[7:1] == 7'h00)
        else $error("reserved bits not zero");
    cov_soft: cover property (serial_if_reset);
    cov_uv: cover property (regulators_off && !serial_if_reset);
    cov_sw: cover property (sw_summary_flag && linear_summary_flag);
endmodule
bind ref_event_flags ref_event_flags_sva i_sva (
    .sys_clk             (sys_clk),
    .rst                 (rst),
    .analog_supply_low   (analog_supply_low),
    .sw_curlimit_active  (sw_curlimit_active),
    .lin_curlimit_active (lin_curlimit_active),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_rdata           (reg_rdata),
    .sw_summary_flag     (sw_summary_flag),
    .linear_summary_flag (linear_summary_flag),
    .regulators_off      (regulators_off),
    .defaults_load       (defaults_load),
    .startup_start       (startup_start),
    .serial_if_reset     (serial_if_reset)
);
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the regulator event flag block.
// Assumes ref_pkg constants; inputs change on the falling clock edge.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module testbench;
    import ref_pkg::*;
    logic            sys_clk, rst, analog_supply_low, reg_wr, reg_rd;
    logic      [7:0] ev, reg_addr, reg_wdata, reg_rdata, e, m;
    logic      [3:0] sh;
    logic            sw_summary_flag, linear_summary_flag, regulators_off;
    logic            defaults_load, startup_start, serial_if_reset;
    wire logic [1:0] sw_powergood_event, sw_curlimit_active, sw_below_short;
    wire logic [1:0] lin_powergood_event, lin_curlimit_active, lin_below_short;
    int              errors, compares, n;
    assign {lin_curlimit_active, lin_powergood_event, sw_curlimit_active, sw_powergood_event} = ev;
    assign {lin_below_short, sw_below_short} = sh;
    ref_event_flags i_dut (
        .sys_clk             (sys_clk),
        .rst                 (rst),
        .analog_supply_low   (analog_supply_low),
        .sw_powergood_event  (sw_powergood_event),
        .sw_below_short      (sw_below_short),
        .sw_curlimit_active  (sw_curlimit_active),
        .lin_powergood_event (lin_powergood_event),
        .lin_below_short     (lin_below_short),
        .lin_curlimit_active (lin_curlimit_active),
        .reg_wr              (reg_wr),
        .reg_rd              (reg_rd),
        .reg_addr            (reg_addr),
        .reg_wdata           (reg_wdata),
        .reg_rdata           (reg_rdata),
        .sw_summary_flag     (sw_summary_flag),
        .linear_summary_flag (linear_summary_flag),
        .regulators_off      (regulators_off),
        .defaults_load       (defaults_load),
        .startup_start       (startup_start),
        .serial_if_reset     (serial_if_reset)
    );
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge sys_clk) reg_wr = 1'b0;
        @(negedge sys_clk);
    endtask
    // Data is held until the next read, so one spare cycle is safe
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge sys_clk) reg_rd = 1'b0;
        @(negedge sys_clk) `CHK(reg_rdata, x)
    endtask
    task automatic test_done;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        {rst, analog_supply_low, reg_wr, reg_rd, ev, reg_addr, reg_wdata, sh} = {1'b1, 31'h0};
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        for (int a = ADDR_SOFT_RESET; a <= 8'h20; a++) rd(8'(a), 8'h00);
        for (int i = 0; i < 8; i++) begin
            e = (i < 4) ? ADDR_SW_EVENT : ADDR_LIN_EVENT;
            m = 8'h01 << (i[1] ? (i[0] ? BIT_REG1_CURLIMIT : BIT_REG0_CURLIMIT)
                : (i[0] ? BIT_REG1_PGOOD : BIT_REG0_PGOOD));
            ev = 8'h01 << i;
            @(negedge sys_clk) ev = 8'h00;
            rd(e, m);
            `CHK(({linear_summary_flag, sw_summary_flag}), ((i < 4) ? 2'b01 : 2'b10))
            rd(ADDR_SUMMARY, 8'h01 << (i < 4 ? BIT_SW_SUMMARY : BIT_LIN_SUMMARY));
            wr(e, ~m);
            rd(e, m);
            wr(e, m);
            rd(e, 8'h00);
            rd(ADDR_SUMMARY, 8'h00);
            `CHK(({linear_summary_flag, sw_summary_flag}), 2'b00)
        end
        // Event and clear in one cycle: the event must survive
        {ev, reg_addr, reg_wdata, reg_wr} = {8'h04, ADDR_SW_EVENT, 8'h01, 1'b1};
        @(negedge sys_clk) {ev, reg_wr} = 9'h000;
        @(negedge sys_clk) rd(ADDR_SW_EVENT, 8'h01);
        sh = 4'b0101;
        repeat (100) @(negedge sys_clk);
        sh = 4'b1010;
        rd(ADDR_SW_EVENT, 8'h01);
        repeat (SHORT_CYCLES - 3) @(negedge sys_clk);
        rd(ADDR_LIN_EVENT, 8'h00);
        rd(ADDR_SW_EVENT, 8'h21);
        sh = 4'b0000;
        rd(ADDR_LIN_EVENT, 8'h20);
        wr(8'h20, 8'hff);
        rd(8'h20, 8'h00);
        {reg_addr, reg_wdata, reg_wr} = {ADDR_SOFT_RESET, 8'h01, 1'b1};
        @(negedge sys_clk) reg_wr = 1'b0;
        `CHK(({serial_if_reset, regulators_off, defaults_load}), 3'b111)
        @(negedge sys_clk) `CHK(({startup_start, serial_if_reset}), 2'b10)
        rd(ADDR_RESET_EVENT, 8'h01);
        rd(ADDR_SW_EVENT, 8'h00);
        rd(ADDR_SOFT_RESET, 8'h00);
        wr(ADDR_RESET_EVENT, 8'hff);
        rd(ADDR_RESET_EVENT, 8'h00);
        analog_supply_low = 1'b1;
        while (!regulators_off && n < 8) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 8) begin
            errors++;
            test_done();
        end
        `CHK(defaults_load, 1'b1)
        @(negedge sys_clk) `CHK(startup_start, 1'b1)
        analog_supply_low = 1'b0;
        rd(ADDR_RESET_EVENT, 8'h01);
        test_done();
    end
endmodule
`default_nettype wire
